// [src/rcr_defs.svh]
// Register map, field positions, reset values and codes of the regulator
// control block. Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

// Register indices; the byte address is four times the index
`define RCR_IDX_ADDITIONAL 7'h07
`define RCR_IDX_STATUS 7'h11
`define RCR_IDX_REGULATOR 7'h35
`define RCR_IDX_BANDGAP 7'h36
`define RCR_IDX_EVENT_STATUS 7'h40
`define RCR_IDX_EVENT_MASK 7'h41

// Address decode
`define RCR_ADDR_W 12
`define RCR_IDX_W 7
`define RCR_IDX_LSB 2

// Field positions
`define RCR_BIT_BIAS_SOURCE_PICK 7
`define RCR_BIT_REG_ON 15
`define RCR_BIT_REF_FAST 14
`define RCR_BIT_REF_PICK 13
`define RCR_BIT_OUT_FLOAT 12
`define RCR_BIT_UV 0
`define RCR_BIT_BG_ON 15
`define RCR_CODE_MSB 4
`define RCR_CODE_LSB 0
`define RCR_BIT_EV_UV_RISE 0
`define RCR_BIT_EV_UV_FALL 1

// Reset values
`define RCR_RST_BIT 1'h0
`define RCR_RST_RATIO 5'h07
`define RCR_RST_BG_LEVEL 5'h0a
`define RCR_RST_EVENTS 2'h0

// Bandgap codes with the top bit set are reserved
`define RCR_BG_RESERVED_BIT 4

// Bus answers
`define RCR_RESP_OKAY 2'h0
`define RCR_RESP_SLVERR 2'h2

`endif

// [src/rcr_pkg.sv]
// Types shared by the regulator control block.
// Assumes the constants of rcr_defs.svh.
package rcr_pkg;

  typedef enum logic [2:0] {
    RCR_SEL_NONE = 3'h0,
    RCR_SEL_ADDITIONAL = 3'h1,
    RCR_SEL_STATUS = 3'h2,
    RCR_SEL_REGULATOR = 3'h3,
    RCR_SEL_BANDGAP = 3'h4,
    RCR_SEL_EVENT_STATUS = 3'h5,
    RCR_SEL_EVENT_MASK = 3'h6
  } rcr_sel_t;

endpackage

// [src/rcr_sync.sv]
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the inputs are quasi-static levels, not pulses.
`timescale 1ns/10ps
module rcr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // rcr_sync

// [src/rcr_axil_slave.sv]
// AXI4-Lite slave handshake: one write and one read in flight at a time.
// Assumes the register file answers wr_ok and rd_ok/rd_data combinationally.
`timescale 1ns/10ps
`include "rcr_defs.svh"
module rcr_axil_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held;
  logic w_held;

  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Address and data are taken in either order and held until committed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_held <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_en) begin
      w_held <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCR_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is captured on the address edge, so it cannot tear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RCR_RESP_OKAY;
    end else if (rd_en) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_data : 32'h0;
      s_axi_rresp <= rd_ok ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // rcr_axil_slave

// [src/rcr_top.sv]
// Control and status registers of the on-chip regulator and its bandgap.
// Assumes an AXI4-Lite master on aclk and an undervoltage comparator level
// arriving asynchronously from the analogue side.
`timescale 1ns/10ps
`include "rcr_defs.svh"
module rcr_top #(
  parameter int ADDR_W = `RCR_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic undervoltage_sense,
  output logic regulator_on,
  output logic bias_source_pick,
  output logic reference_pick,
  output logic reference_fast_pick,
  output logic output_discharge,
  output logic output_float_when_off,
  output logic [4:0] output_ratio_code,
  output logic bandgap_on,
  output logic [4:0] bandgap_level_code,
  output logic undervoltage_pin,
  output logic irq
);

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  rcr_pkg::rcr_sel_t wr_sel;
  rcr_pkg::rcr_sel_t rd_sel;
  logic undervoltage_flag;
  logic uv_prev;
  logic reference_fast_raw;
  logic [1:0] event_status;
  logic [1:0] event_mask;
  logic [1:0] event_set;
  logic lo_we;
  logic hi_we;
  logic add_we;
  logic reg_hi_we;
  logic reg_lo_we;
  logic bg_hi_we;
  logic bg_lo_we;
  logic evs_we;
  logic evm_we;

  // Shared decode for reads and writes; misaligned addresses are unmapped
  function automatic rcr_pkg::rcr_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [`RCR_IDX_W-1:0] idx;
    idx = a[`RCR_IDX_LSB +: `RCR_IDX_W];
    if (a[`RCR_IDX_LSB-1:0] != '0 ||
        a[ADDR_W-1:`RCR_IDX_LSB+`RCR_IDX_W] != '0) begin
      return rcr_pkg::RCR_SEL_NONE;
    end
    unique case (idx)
      `RCR_IDX_ADDITIONAL: return rcr_pkg::RCR_SEL_ADDITIONAL;
      `RCR_IDX_STATUS: return rcr_pkg::RCR_SEL_STATUS;
      `RCR_IDX_REGULATOR: return rcr_pkg::RCR_SEL_REGULATOR;
      `RCR_IDX_BANDGAP: return rcr_pkg::RCR_SEL_BANDGAP;
      `RCR_IDX_EVENT_STATUS: return rcr_pkg::RCR_SEL_EVENT_STATUS;
      `RCR_IDX_EVENT_MASK: return rcr_pkg::RCR_SEL_EVENT_MASK;
      default: return rcr_pkg::RCR_SEL_NONE;
    endcase
  endfunction

  // Strobe of one byte lane of one register, shared by every write below
  function automatic logic lane_hit(input rcr_pkg::rcr_sel_t sel,
                                    input rcr_pkg::rcr_sel_t want,
                                    input logic lane_we);
    return lane_we && (sel == want);
  endfunction

  rcr_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  rcr_sync #(
    .WIDTH(1)
  ) u_uv_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(undervoltage_sense),
    .sync_out(undervoltage_flag)
  );

  assign wr_sel = decode(wr_addr);
  assign rd_sel = decode(rd_addr);
  assign wr_ok = (wr_sel != rcr_pkg::RCR_SEL_NONE);
  assign rd_ok = (rd_sel != rcr_pkg::RCR_SEL_NONE);
  // All fields live in the low 16 bits; byte lanes 2 and 3 are ignored
  assign lo_we = wr_en && wr_strb[0];
  assign hi_we = wr_en && wr_strb[1];
  assign add_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_ADDITIONAL, lo_we);
  assign reg_hi_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_REGULATOR, hi_we);
  assign reg_lo_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_REGULATOR, lo_we);
  assign bg_hi_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_BANDGAP, hi_we);
  assign bg_lo_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_BANDGAP, lo_we);
  assign evs_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_EVENT_STATUS, lo_we);
  assign evm_we = lane_hit(wr_sel, rcr_pkg::RCR_SEL_EVENT_MASK, lo_we);

  // Additional control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_source_pick <= `RCR_RST_BIT;
    end else if (add_we) begin
      bias_source_pick <= wr_data[`RCR_BIT_BIAS_SOURCE_PICK];
    end
  end

  // Regulator control register, high byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_on <= `RCR_RST_BIT;
      reference_fast_raw <= `RCR_RST_BIT;
      reference_pick <= `RCR_RST_BIT;
      output_float_when_off <= `RCR_RST_BIT;
    end else if (reg_hi_we) begin
      regulator_on <= wr_data[`RCR_BIT_REG_ON];
      reference_fast_raw <= wr_data[`RCR_BIT_REF_FAST];
      reference_pick <= wr_data[`RCR_BIT_REF_PICK];
      output_float_when_off <= wr_data[`RCR_BIT_OUT_FLOAT];
    end
  end

  // Regulator control register, low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_ratio_code <= `RCR_RST_RATIO;
    end else if (reg_lo_we) begin
      output_ratio_code <= wr_data[`RCR_CODE_MSB:`RCR_CODE_LSB];
    end
  end

  // Analogue steering derived from the stored bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reference_fast_pick <= `RCR_RST_BIT;
      output_discharge <= 1'b1;
    end else begin
      // Fast string only matters while the midrail is the reference
      reference_fast_pick <= reference_fast_raw && !reference_pick;
      output_discharge <= !regulator_on && !output_float_when_off;
    end
  end

  // Bandgap register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bandgap_on <= `RCR_RST_BIT;
      bandgap_level_code <= `RCR_RST_BG_LEVEL;
    end else begin
      if (bg_hi_we) begin
        bandgap_on <= wr_data[`RCR_BIT_BG_ON];
      end
      // Reserved codes are dropped so the bandgap never leaves its range
      if (bg_lo_we && !wr_data[`RCR_BG_RESERVED_BIT]) begin
        bandgap_level_code <= wr_data[`RCR_CODE_MSB:`RCR_CODE_LSB];
      end
    end
  end

  // Undervoltage pin and edge events
  assign event_set[`RCR_BIT_EV_UV_RISE] = undervoltage_flag && !uv_prev;
  assign event_set[`RCR_BIT_EV_UV_FALL] = !undervoltage_flag && uv_prev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uv_prev <= `RCR_RST_BIT;
      undervoltage_pin <= `RCR_RST_BIT;
    end else begin
      uv_prev <= undervoltage_flag;
      undervoltage_pin <= undervoltage_flag;
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_status <= `RCR_RST_EVENTS;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (event_set[i]) begin
          event_status[i] <= 1'b1;
        end else if (evs_we && wr_data[i]) begin
          event_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_mask <= `RCR_RST_EVENTS;
    end else if (evm_we) begin
      event_mask <= wr_data[1:0];
    end
  end

  // Registered, so irq lags the status bit by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // Read mux; bits outside defined fields read zero
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_sel)
      rcr_pkg::RCR_SEL_ADDITIONAL: begin
        rd_data[`RCR_BIT_BIAS_SOURCE_PICK] = bias_source_pick;
      end
      rcr_pkg::RCR_SEL_STATUS: begin
        rd_data[`RCR_BIT_UV] = undervoltage_flag;
      end
      rcr_pkg::RCR_SEL_REGULATOR: begin
        rd_data[`RCR_BIT_REG_ON] = regulator_on;
        rd_data[`RCR_BIT_REF_FAST] = reference_fast_raw;
        rd_data[`RCR_BIT_REF_PICK] = reference_pick;
        rd_data[`RCR_BIT_OUT_FLOAT] = output_float_when_off;
        rd_data[`RCR_CODE_MSB:`RCR_CODE_LSB] = output_ratio_code;
      end
      rcr_pkg::RCR_SEL_BANDGAP: begin
        rd_data[`RCR_BIT_BG_ON] = bandgap_on;
        rd_data[`RCR_CODE_MSB:`RCR_CODE_LSB] = bandgap_level_code;
      end
      rcr_pkg::RCR_SEL_EVENT_STATUS: begin
        rd_data[1:0] = event_status;
      end
      rcr_pkg::RCR_SEL_EVENT_MASK: begin
        rd_data[1:0] = event_mask;
      end
      rcr_pkg::RCR_SEL_NONE: begin
        rd_data = 32'h0;
      end
    endcase
  end

endmodule // rcr_top

// [verification/rcr_top_props.sv]
// Port-level assertions for the regulator control block.
// Assumes one clock aclk and a synchronous active-low aresetn.
`timescale 1ns/10ps
module rcr_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic undervoltage_sense,
  input wire logic regulator_on,
  input wire logic bias_source_pick,
  input wire logic reference_pick,
  input wire logic reference_fast_pick,
  input wire logic output_discharge,
  input wire logic output_float_when_off,
  input wire logic [4:0] output_ratio_code,
  input wire logic [4:0] bandgap_level_code,
  input wire logic undervoltage_pin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_values: assert property (
    $rose(aresetn) |-> !regulator_on && output_discharge
    && output_ratio_code == 5'h07 && bandgap_level_code == 5'h0a)
    else $error("outputs differ from reset values");
  a_discharge_follows: assert property (
    output_discharge != ($past(regulator_on) || $past(output_float_when_off)))
    else $error("discharge does not follow enable and float");
  a_fast_gated: assert property (
    reference_fast_pick |-> !$past(reference_pick))
    else $error("fast string picked while bandgap is the reference");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_resp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_uv_pin_rise: assert property (
    $rose(undervoltage_sense) |-> ##[1:6] undervoltage_pin)
    else $error("undervoltage pin did not follow");
  a_uv_pin_quiet: assert property (
    (!undervoltage_sense) [*6] |-> !undervoltage_pin)
    else $error("undervoltage pin high without cause");
  a_cfg_on_write: assert property (
    $changed(regulator_on) || $changed(bias_source_pick)
    || $changed(reference_pick) || $changed(output_ratio_code)
    || $changed(bandgap_level_code) |-> $rose(s_axi_bvalid))
    else $error("control output changed without a write");
  a_bg_code_legal: assert property (
    !bandgap_level_code[4])
    else $error("reserved bandgap code reached the output");
endmodule // rcr_top_props

bind rcr_top rcr_top_props i_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .undervoltage_sense(undervoltage_sense), .regulator_on(regulator_on),
  .bias_source_pick(bias_source_pick), .reference_pick(reference_pick),
  .reference_fast_pick(reference_fast_pick),
  .output_discharge(output_discharge),
  .output_float_when_off(output_float_when_off),
  .output_ratio_code(output_ratio_code),
  .bandgap_level_code(bandgap_level_code),
  .undervoltage_pin(undervoltage_pin)
);

// [verification/test_regulator_control_registers.sv]
// Self-checking bench for the regulator control block.
// Assumes rcr_top, its AXI4-Lite map and the checker bound to it.
`timescale 1ns/10ps
`include "rcr_defs.svh"
module test_regulator_control_registers;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, undervoltage_sense = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic regulator_on, bias_source_pick, reference_pick, reference_fast_pick;
  logic output_discharge, output_float_when_off, bandgap_on, undervoltage_pin;
  logic irq;
  logic [4:0] output_ratio_code, bandgap_level_code;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  rcr_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .undervoltage_sense(undervoltage_sense),
    .regulator_on(regulator_on), .bias_source_pick(bias_source_pick),
    .reference_pick(reference_pick),
    .reference_fast_pick(reference_fast_pick),
    .output_discharge(output_discharge),
    .output_float_when_off(output_float_when_off),
    .output_ratio_code(output_ratio_code), .bandgap_on(bandgap_on),
    .bandgap_level_code(bandgap_level_code),
    .undervoltage_pin(undervoltage_pin), .irq(irq)
  );

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // A hung handshake would stall the run forever, so cap its length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [11:0] ad(input logic [6:0] idx);
    return {3'h0, idx, 2'h0};
  endfunction

  // Flags: on, bias, ref, fast, discharge, float, bg on, irq, pin
  task automatic ok(input logic [8:0] f, input logic [4:0] r,
                    input logic [4:0] b);
    chk({13'h0, regulator_on, bias_source_pick, reference_pick,
         reference_fast_pick, output_discharge, output_float_when_off,
         bandgap_on, irq, undervoltage_pin, output_ratio_code,
         bandgap_level_code}, {13'h0, f, r, b});
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] d,
                    input logic [1:0] resp);
    logic a;
    logic w;
    // Local flags: the valids' own updates have not landed yet here
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= ad(idx);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (a && s_axi_awready) begin
        a = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Ready from the edge that took the request until the answer is seen
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(resp));
  endtask

  task automatic rd(input logic [6:0] idx, input logic [31:0] exp,
                    input logic [1:0] resp);
    s_axi_araddr <= ad(idx);
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(resp));
  endtask

  task automatic t_reset();
    ok(9'h010, 5'h07, 5'h0a);
    rd(`RCR_IDX_ADDITIONAL, 32'h0, 2'h0);
    rd(`RCR_IDX_STATUS, 32'h0, 2'h0);
    rd(`RCR_IDX_REGULATOR, 32'h0007, 2'h0);
    rd(`RCR_IDX_BANDGAP, 32'h000a, 2'h0);
    rd(`RCR_IDX_EVENT_MASK, 32'h0, 2'h0);
  endtask

  task automatic t_regulator();
    wr(`RCR_IDX_ADDITIONAL, 32'h0000_0080, 2'h0);
    wr(`RCR_IDX_BANDGAP, 32'h0000_800a, 2'h0);
    wr(`RCR_IDX_REGULATOR, 32'hffff_ffff, 2'h0);
    rd(`RCR_IDX_REGULATOR, 32'h0000_f01f, 2'h0);
    ok(9'h1cc, 5'h1f, 5'h0a);
    wr(`RCR_IDX_REGULATOR, 32'h0000_5000, 2'h0);
    rd(`RCR_IDX_REGULATOR, 32'h0000_5000, 2'h0);
    ok(9'h0ac, 5'h00, 5'h0a);
    wr(`RCR_IDX_REGULATOR, 32'h0000_6000, 2'h0);
    rd(`RCR_IDX_REGULATOR, 32'h0000_6000, 2'h0);
    ok(9'h0d4, 5'h00, 5'h0a);
    wr(`RCR_IDX_REGULATOR, 32'h0000_8000, 2'h0);
    rd(`RCR_IDX_REGULATOR, 32'h0000_8000, 2'h0);
    ok(9'h184, 5'h00, 5'h0a);
  endtask

  task automatic t_additional();
    wr(`RCR_IDX_ADDITIONAL, 32'hffff_ffff, 2'h0);
    rd(`RCR_IDX_ADDITIONAL, 32'h0000_0080, 2'h0);
    ok(9'h184, 5'h00, 5'h0a);
  endtask

  task automatic t_bandgap();
    wr(`RCR_IDX_BANDGAP, 32'h0000_800f, 2'h0);
    rd(`RCR_IDX_BANDGAP, 32'h0000_800f, 2'h0);
    ok(9'h184, 5'h00, 5'h0f);
    wr(`RCR_IDX_BANDGAP, 32'h0000_0010, 2'h0);
    rd(`RCR_IDX_BANDGAP, 32'h0000_000f, 2'h0);
    ok(9'h180, 5'h00, 5'h0f);
  endtask

  task automatic t_refused();
    wr(`RCR_IDX_STATUS, 32'h0000_0001, 2'h0);
    rd(`RCR_IDX_STATUS, 32'h0, 2'h0);
    wr(7'h10, 32'h0000_ffff, 2'h2);
    rd(7'h10, 32'h0, 2'h2);
  endtask

  task automatic t_undervoltage();
    wr(`RCR_IDX_EVENT_MASK, 32'h0000_0003, 2'h0);
    undervoltage_sense <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(`RCR_IDX_STATUS, 32'h0000_0001, 2'h0);
    rd(`RCR_IDX_EVENT_STATUS, 32'h0000_0001, 2'h0);
    ok(9'h183, 5'h00, 5'h0f);
    wr(`RCR_IDX_EVENT_STATUS, 32'h0000_0001, 2'h0);
    rd(`RCR_IDX_EVENT_STATUS, 32'h0, 2'h0);
    ok(9'h181, 5'h00, 5'h0f);
    undervoltage_sense <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(`RCR_IDX_STATUS, 32'h0, 2'h0);
    rd(`RCR_IDX_EVENT_STATUS, 32'h0000_0002, 2'h0);
    ok(9'h182, 5'h00, 5'h0f);
    wr(`RCR_IDX_EVENT_MASK, 32'h0000_0001, 2'h0);
    rd(`RCR_IDX_EVENT_MASK, 32'h0000_0001, 2'h0);
    ok(9'h180, 5'h00, 5'h0f);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regulator();
    t_additional();
    t_bandgap();
    t_refused();
    t_undervoltage();
    tally_and_finish();
  end
endmodule // test_regulator_control_registers
